// *** src/pf_check_pkg.sv ***
/*
  Shared types and constants for the permanent-fail checker: measurement and
  configuration carriers, fail flag layout, default settings and tick timing.
  Assumes a single 250 MHz clock and measurements already in that domain.
*/
package pf_check_pkg;

  // ****************************************
  // Widths
  // ****************************************
  localparam int DELAY_W   = 8;
  localparam int RELAX_W   = 16;
  localparam int MV_W      = 16;
  localparam int SUM_W     = 20;
  localparam int CUR_W     = 16;
  localparam int TEMP_W    = 8;
  localparam int CELLS_W   = 5;
  localparam int SCALED_W  = MV_W + CELLS_W;
  localparam int DIFF_W    = SUM_W + 1;
  localparam int TICK_W    = 28;

  // ****************************************
  // Timing
  // ****************************************
  localparam longint TICK_PERIOD_NS = 1000000000;
  localparam longint CLK_PERIOD_NS  = 4;
  localparam int     TICK_CYCLES    = int'(TICK_PERIOD_NS / CLK_PERIOD_NS);

  // ****************************************
  // Default settings
  // ****************************************
  localparam logic [MV_W-1:0]           OV_THRESH_DEF      = 16'h1194;
  localparam logic [MV_W-1:0]           STACK_THRESH_DEF   = 16'h01F4;
  localparam logic signed [CUR_W-1:0]   CHG_OC_THRESH_DEF  = 16'sh2710;
  localparam logic signed [CUR_W-1:0]   DSG_OC_THRESH_DEF  = 16'sh8300;
  localparam logic signed [TEMP_W-1:0]  CELL_OT_THRESH_DEF = 8'sh41;
  localparam logic [TEMP_W-1:0]         FET_OT_THRESH_DEF  = 8'h55;
  localparam logic [MV_W-1:0]           IMB_CHECK_MV_DEF   = 16'h0DAC;
  localparam logic [CUR_W-1:0]          IMB_RELAX_CUR_DEF  = 16'h000A;
  localparam logic [MV_W-1:0]           IMB_THRESH_DEF     = 16'h01F4;
  localparam logic [RELAX_W-1:0]        IMB_RELAX_DUR_DEF  = 16'h0064;
  localparam logic [DELAY_W-1:0]        DELAY_DEF          = 8'h05;

  // ****************************************
  // Fail flag positions
  // ****************************************
  localparam int FAIL_OV     = 0;
  localparam int FAIL_STACK  = 1;
  localparam int FAIL_CHG_OC = 2;
  localparam int FAIL_DSG_OC = 3;
  localparam int FAIL_CELL_OT = 4;
  localparam int FAIL_FET_OT = 5;
  localparam int FAIL_IMB    = 6;
  localparam int NUM_CHECKS  = 7;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [MV_W-1:0]          max_cell_mv;
    logic [MV_W-1:0]          min_cell_mv;
    logic [SUM_W-1:0]         cell_sum_mv;
    logic [SUM_W-1:0]         stack_mv;
    logic signed [CUR_W-1:0]  current;
    logic [CUR_W-1:0]         stack_peak_abs_current;
    logic signed [TEMP_W-1:0] max_cell_temp;
    logic [TEMP_W-1:0]        fet_temp;
  } meas_type;

  typedef struct packed {
    logic [MV_W-1:0]          ov_thresh;
    logic [MV_W-1:0]          stack_thresh;
    logic [CELLS_W-1:0]       cells_used;
    logic [CUR_W-1:0]         sleep_current;
    logic signed [CUR_W-1:0]  chg_oc_thresh;
    logic signed [CUR_W-1:0]  dsg_oc_thresh;
    logic signed [TEMP_W-1:0] cell_ot_thresh;
    logic [TEMP_W-1:0]        fet_ot_thresh;
    logic [MV_W-1:0]          imb_check_mv;
    logic [CUR_W-1:0]         imb_relax_current;
    logic [MV_W-1:0]          imb_thresh;
    logic [RELAX_W-1:0]       imb_relax_dur;
  } cfg_type;

  typedef logic [NUM_CHECKS-1:0][DELAY_W-1:0] delay_set_type;
  typedef logic [NUM_CHECKS-1:0]              fail_flags_type;

endpackage

// *** src/pf_persist.sv ***
/*
  One persistence counter: counts one-second ticks while its condition holds
  and latches a fail flag once the count reaches the configured delay.
  Assumes tick and condition come from logic on the same clock.
*/
`timescale 1ns/1ns
module pf_persist
  import pf_check_pkg::*;
(
  input  wire logic               ref_clk_in,
  input  wire logic               resetn_in,
  input  wire logic               tick_in,
  input  wire logic               cond_in,
  input  wire logic [DELAY_W-1:0] delay_in,
  output logic                    fail_out
);

  logic [DELAY_W-1:0] count_r;
  logic [DELAY_W-1:0] count_nxt;

  // Saturate so a condition held past 255 s cannot wrap back to zero
  assign count_nxt = (count_r == {DELAY_W{1'b1}}) ? count_r : count_r + 8'h01;

  // ****************************************
  // Seconds counter
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      count_r <= '0;
    end else if (!cond_in) begin
      count_r <= '0;
    end else if (tick_in) begin
      count_r <= count_nxt;
    end
  end

  // ****************************************
  // Sticky fail flag
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      fail_out <= 1'b0;
    end else if (cond_in && tick_in && (count_nxt >= delay_in)) begin
      fail_out <= 1'b1;
    end
  end
  // No clear path besides reset

endmodule

// *** src/safety_permanent_fail_checker.sv ***
/*
  Permanent-fail checker for a battery-pack monitor: seven threshold checks,
  each with a seconds persistence delay, and a combined permanent-fail flag.
  Assumes measurements and settings are steady values on the same clock,
  updated by the measurement subsystem and host configuration logic.
*/
`timescale 1ns/1ns
module safety_permanent_fail_checker
  import pf_check_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input  wire logic           ref_clk_in,
  input  wire logic           resetn_in,
  input  wire meas_type       meas_in,
  input  wire cfg_type        cfg_in,
  input  wire delay_set_type  delay_in,
  output fail_flags_type      fail_flags_out,
  output logic                permanent_fail_out,
  output logic                rest_qualified_out,
  output logic                tick_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [CUR_W:0] abs_current(input logic signed [CUR_W-1:0] v);
    logic [CUR_W:0] ext;
    ext = {v[CUR_W-1], v};
    if (v[CUR_W-1]) begin
      abs_current = ~ext + 17'h00001;
    end else begin
      abs_current = ext;
    end
  endfunction

  function automatic logic [DIFF_W-1:0] abs_diff(input logic [SUM_W-1:0] a,
                                                 input logic [SUM_W-1:0] b);
    if (a >= b) begin
      abs_diff = {1'b0, a - b};
    end else begin
      abs_diff = {1'b0, b - a};
    end
  endfunction

  // ****************************************
  // One-second tick divider
  // ****************************************
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);

  logic [TICK_W-1:0] tick_cnt_r;
  logic              tick_r;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tick_cnt_r <= '0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 28'h0000001;
    end
  end

  // Registered pulse so every check sees the same second boundary
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_LAST);
    end
  end

  assign tick_out = tick_r;

  // ****************************************
  // Cell overvoltage
  // ****************************************
  logic ov_cond;

  assign ov_cond = (meas_in.max_cell_mv >= cfg_in.ov_thresh);

  // ****************************************
  // Stack versus cell sum
  // ****************************************
  logic [SCALED_W-1:0] stack_limit;
  logic [DIFF_W-1:0]   stack_diff;
  logic                stack_quiet;
  logic                stack_cond;

  // Product is wide enough for 16 cells at full-scale threshold
  assign stack_limit = SCALED_W'(cfg_in.stack_thresh) * SCALED_W'(cfg_in.cells_used);
  assign stack_diff  = abs_diff(meas_in.stack_mv, meas_in.cell_sum_mv);
  // Peak current is sampled by the measurement side across all involved conversions
  assign stack_quiet = (meas_in.stack_peak_abs_current <= cfg_in.sleep_current);
  assign stack_cond  = stack_quiet && (stack_diff >= DIFF_W'(stack_limit));

  // ****************************************
  // Charge overcurrent
  // ****************************************
  logic chg_oc_cond;

  assign chg_oc_cond = ($signed(meas_in.current) >= $signed(cfg_in.chg_oc_thresh));

  // ****************************************
  // Discharge overcurrent
  // ****************************************
  logic dsg_oc_cond;

  // Kept greater-or-equal; a negative default is met by nearly any current
  assign dsg_oc_cond = ($signed(meas_in.current) >= $signed(cfg_in.dsg_oc_thresh));

  // ****************************************
  // Cell overtemperature
  // ****************************************
  logic cell_ot_cond;

  assign cell_ot_cond = ($signed(meas_in.max_cell_temp)
                         >= $signed(cfg_in.cell_ot_thresh));

  // ****************************************
  // FET overtemperature
  // ****************************************
  logic fet_ot_cond;

  assign fet_ot_cond = (meas_in.fet_temp >= cfg_in.fet_ot_thresh);

  // ****************************************
  // Rest imbalance
  // ****************************************
  logic [CUR_W:0]  cur_abs;
  logic [MV_W-1:0] cell_spread;
  logic            rest_cond;
  logic            imb_cond;

  assign cur_abs     = abs_current(meas_in.current);
  assign cell_spread = (meas_in.max_cell_mv >= meas_in.min_cell_mv) ?
                       (meas_in.max_cell_mv - meas_in.min_cell_mv) : '0;

  assign rest_cond = (meas_in.max_cell_mv >= cfg_in.imb_check_mv)
                   && (cur_abs < {1'b0, cfg_in.imb_relax_current});
  assign imb_cond  = rest_cond && rest_qualified_out
                   && (cell_spread >= cfg_in.imb_thresh);

  // ****************************************
  // Condition vector
  // ****************************************
  logic [NUM_CHECKS-1:0] cond;

  always_comb begin
    cond = '0;
    cond[FAIL_OV]      = ov_cond;
    cond[FAIL_STACK]   = stack_cond;
    cond[FAIL_CHG_OC]  = chg_oc_cond;
    cond[FAIL_DSG_OC]  = dsg_oc_cond;
    cond[FAIL_CELL_OT] = cell_ot_cond;
    cond[FAIL_FET_OT]  = fet_ot_cond;
    cond[FAIL_IMB]     = imb_cond;
  end

  // ****************************************
  // Rest qualification timer
  // ****************************************
  logic [RELAX_W-1:0] relax_cnt_r;
  logic [RELAX_W-1:0] relax_cnt_nxt;

  assign relax_cnt_nxt = (relax_cnt_r == {RELAX_W{1'b1}}) ? relax_cnt_r
                                                          : relax_cnt_r + 16'h0001;

  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      relax_cnt_r <= '0;
    end else if (!rest_cond) begin
      relax_cnt_r <= '0;
    end else if (tick_r) begin
      relax_cnt_r <= relax_cnt_nxt;
    end
  end

  // A zero duration qualifies at once; a lapse drops qualification the same cycle
  assign rest_qualified_out = rest_cond && (relax_cnt_r >= cfg_in.imb_relax_dur);

  // ****************************************
  // Persistence counters
  // ****************************************
  fail_flags_type fails;

  for (genvar i = 0; i < NUM_CHECKS; i++) begin : g_check
    pf_persist u_persist (
      .ref_clk_in (ref_clk_in),
      .resetn_in  (resetn_in),
      .tick_in    (tick_r),
      .cond_in    (cond[i]),
      .delay_in   (delay_in[i]),
      .fail_out   (fails[i])
    );
  end

  assign fail_flags_out = fails;

  // ****************************************
  // Combined permanent fail
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      permanent_fail_out <= 1'b0;
    end else if (|fails) begin
      permanent_fail_out <= 1'b1;
    end
  end

endmodule

// *** tb/meas_model.sv ***
/*
  Measurement subsystem stand-in: presents the requested measurement set
  as registered levels. Assumes one clock shared with the checker.
*/
`timescale 1ns/1ns
module meas_model
  import pf_check_pkg::*;
(
  input  wire logic     ref_clk_in,
  input  wire meas_type req_in,
  output meas_type      meas_out
);
  // ****
  // Levels
  // ****
  // Registered so a new set lands whole, never half updated
  always_ff @(posedge ref_clk_in) begin
    meas_out <= req_in;
  end
endmodule

// *** tb/pf_check_properties.sv ***
/*
  Port checker for the permanent-fail block: tick spacing, sticky flags,
  flag causes. Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module pf_check_properties
  import pf_check_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
)
(
  input wire logic           ref_clk_in,
  input wire logic           resetn_in,
  input wire meas_type       meas_in,
  input wire cfg_type        cfg_in,
  input wire delay_set_type  delay_in,
  input wire fail_flags_type fail_flags_out,
  input wire logic           permanent_fail_out,
  input wire logic           rest_qualified_out,
  input wire logic           tick_out
);
  // ****
  // Helpers
  // ****
  int unsigned      tick_gap_r;
  logic [CUR_W:0]   abs_cur;
  assign abs_cur = meas_in.current[CUR_W-1] ? -{1'b1, meas_in.current} : {1'b0, meas_in.current};
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) tick_gap_r <= 0;
    else if (tick_out) tick_gap_r <= 1;
    else tick_gap_r <= tick_gap_r + 1;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // ****
  // Properties
  // ****
  property p_sticky; 1 |=> (fail_flags_out & $past(fail_flags_out)) == $past(fail_flags_out);
  endproperty
  a_sticky: assert property (p_sticky) else $error("fail flag dropped");
  property p_pf; 1 |=> permanent_fail_out == |$past(fail_flags_out); endproperty
  a_pf: assert property (p_pf) else $error("combined flag wrong");
  property p_tick_only; !tick_out |=> $stable(fail_flags_out); endproperty
  a_tick_only: assert property (p_tick_only) else $error("flag moved off tick");
  property p_tick_spacing; tick_out |-> tick_gap_r == TICK_COUNT; endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick early");
  property p_tick_due; tick_gap_r <= TICK_COUNT; endproperty
  a_tick_due: assert property (p_tick_due) else $error("tick late");
  property p_ov; !fail_flags_out[FAIL_OV] && meas_in.max_cell_mv < cfg_in.ov_thresh
    |=> !fail_flags_out[FAIL_OV]; endproperty
  a_ov: assert property (p_ov) else $error("overvoltage flag without cause");
  property p_chg; !fail_flags_out[FAIL_CHG_OC] && meas_in.current < cfg_in.chg_oc_thresh
    |=> !fail_flags_out[FAIL_CHG_OC]; endproperty
  a_chg: assert property (p_chg) else $error("charge flag without cause");
  property p_cot; !fail_flags_out[FAIL_CELL_OT] && meas_in.max_cell_temp < cfg_in.cell_ot_thresh
    |=> !fail_flags_out[FAIL_CELL_OT]; endproperty
  a_cot: assert property (p_cot) else $error("cell temp flag without cause");
  property p_skip; !fail_flags_out[FAIL_STACK]
    && meas_in.stack_peak_abs_current > cfg_in.sleep_current |=> !fail_flags_out[FAIL_STACK];
  endproperty
  a_skip: assert property (p_skip) else $error("stack flag while loaded");
  property p_qual; rest_qualified_out |-> meas_in.max_cell_mv >= cfg_in.imb_check_mv
    && abs_cur < {1'b0, cfg_in.imb_relax_current}; endproperty
  a_qual: assert property (p_qual) else $error("rest qualified wrongly");
  property p_imb; !fail_flags_out[FAIL_IMB] && !rest_qualified_out |=> !fail_flags_out[FAIL_IMB];
  endproperty
  a_imb: assert property (p_imb) else $error("imbalance flag unqualified");
  c_pf: cover property (permanent_fail_out);
  c_rest: cover property ($rose(rest_qualified_out));
  c_imb: cover property (fail_flags_out[FAIL_IMB]);
endmodule
bind safety_permanent_fail_checker pf_check_properties #(.TICK_COUNT(TICK_COUNT)) pf_props_i (
  .ref_clk_in, .resetn_in, .meas_in, .cfg_in, .delay_in, .fail_flags_out, .permanent_fail_out,
  .rest_qualified_out, .tick_out);

// *** tb/tb.sv ***
/*
  Scenario bench for the permanent-fail block with a short tick.
  Assumes the measurement stand-in and the bound checker.
*/
`timescale 1ns/1ns
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import pf_check_pkg::*;
;
  // ****
  // Bench
  // ****
  localparam int  TC = 10;
  logic           ref_clk_in = 1'b0;
  logic           resetn_in = 1'b0;
  meas_type       req, base_m, m, meas_in;
  cfg_type        cfg_in, base_c, c;
  delay_set_type  delay_in = '0;
  fail_flags_type fail_flags_out;
  logic           permanent_fail_out, rest_qualified_out, tick_out;
  int             num_errors = 0;
  int             samples_checked = 0;
  always #2 ref_clk_in = ~ref_clk_in;
  meas_model meas_model_i (.ref_clk_in, .req_in(req), .meas_out(meas_in));
  safety_permanent_fail_checker #(.TICK_COUNT(TC)) safety_permanent_fail_checker_i (
    .ref_clk_in, .resetn_in, .meas_in, .cfg_in, .delay_in, .fail_flags_out,
    .permanent_fail_out, .rest_qualified_out, .tick_out);
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Bounded so a dead tick cannot hang the run
  task automatic ticks(input int n);
    int k = 0;
    for (int i = 0; i < (n + 1) * TC && k < n; i++) begin
      @(negedge ref_clk_in);
      if (tick_out === 1'b1) k++;
    end
    if (k < n) begin
      num_errors++;
      print_verdict();
    end
  endtask
  task automatic scen(input meas_type sm, input cfg_type sc, input int d, input int n,
                      input fail_flags_type e);
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    req <= sm;
    cfg_in <= sc;
    delay_in <= {NUM_CHECKS{DELAY_W'(d)}};
    repeat (12) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    ticks(n - 1);
    @(negedge ref_clk_in);
    `CHK(fail_flags_out, 7'h00)
    ticks(1);
    @(negedge ref_clk_in);
    `CHK(fail_flags_out, e)
    @(negedge ref_clk_in);
    `CHK(permanent_fail_out, |e)
    @(posedge ref_clk_in);
    req <= base_m;
    ticks(2);
    @(negedge ref_clk_in);
    `CHK(fail_flags_out, e)
    $display("scenario done at %0t", $time);
  endtask
  initial begin
    base_m = '{16'h0BB8, 16'h0BB8, 20'h02EE0, 20'h02EE0, 16'sh0000, 16'h0000, 8'sh19, 8'h19};
    base_c = '{OV_THRESH_DEF, STACK_THRESH_DEF, 5'h04, 16'h000A, CHG_OC_THRESH_DEF, 16'sh7FFF,
               CELL_OT_THRESH_DEF, FET_OT_THRESH_DEF, IMB_CHECK_MV_DEF, IMB_RELAX_CUR_DEF,
               IMB_THRESH_DEF, 16'h0002};
    req = base_m;
    cfg_in = base_c;
    m = base_m;
    m.max_cell_mv = OV_THRESH_DEF;
    scen(m, base_c, 3, 3, 7'h01);
    scen(m, base_c, 0, 1, 7'h01);
    scen(m, base_c, 255, 255, 7'h01);
    m.max_cell_mv = 16'h1193;
    scen(m, base_c, 3, 3, 7'h00);
    m = base_m;
    m.stack_mv = 20'h03E80;
    m.cell_sum_mv = 20'h036B0;
    scen(m, base_c, 3, 3, 7'h02);
    m.cell_sum_mv = 20'h036B1;
    scen(m, base_c, 3, 3, 7'h00);
    m.stack_mv = 20'h036B0;
    m.cell_sum_mv = 20'h03E80;
    scen(m, base_c, 3, 3, 7'h02);
    m.stack_peak_abs_current = 16'h000B;
    scen(m, base_c, 3, 3, 7'h00);
    m = base_m;
    m.current = CHG_OC_THRESH_DEF;
    scen(m, base_c, 3, 3, 7'h04);
    c = base_c;
    c.dsg_oc_thresh = DSG_OC_THRESH_DEF;
    m.current = DSG_OC_THRESH_DEF;
    scen(m, c, 3, 3, 7'h08);
    m.current = 16'sh82FF;
    scen(m, c, 3, 3, 7'h00);
    m = base_m;
    m.max_cell_temp = CELL_OT_THRESH_DEF;
    scen(m, base_c, 3, 3, 7'h10);
    m.max_cell_temp = 8'sh80;
    scen(m, base_c, 3, 3, 7'h00);
    m = base_m;
    m.fet_temp = 8'h96;
    scen(m, base_c, 3, 3, 7'h20);
    m = base_m;
    m.max_cell_mv = 16'h0E10;
    m.min_cell_mv = 16'h0C1C;
    scen(m, base_c, 5, 7, 7'h40);
    m.current = 16'shFFF6;
    scen(m, base_c, 5, 7, 7'h00);
    m.current = 16'sh0000;
    m.max_cell_mv = 16'h0DAB;
    m.min_cell_mv = 16'h0BB7;
    scen(m, base_c, 5, 7, 7'h00);
    print_verdict();
  end
endmodule
